// >>> otm_map.vh
`ifndef OTM_MAP_VH
`define OTM_MAP_VH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define OTM_REG_SEL_OC1        5'h00
`define OTM_REG_SEL_OC2        5'h01
`define OTM_REG_SEL_OC3        5'h02
`define OTM_REG_SEL_OC4        5'h03
`define OTM_REG_SEL_OC5        5'h04
`define OTM_REG_SEL_RLY1       5'h05
`define OTM_REG_SEL_RLY2       5'h06
`define OTM_REG_START_FREQ     5'h07
`define OTM_REG_SU_BAND        5'h08
`define OTM_REG_FDET1          5'h09
`define OTM_REG_FDET1_REV      5'h0A
`define OTM_REG_FDET2          5'h0B
`define OTM_REG_FDET3          5'h0C
`define OTM_REG_REGEN_LIMIT    5'h0D
`define OTM_REG_THERM_TRIP     5'h0E
`define OTM_REG_CUR_THR        5'h0F
`define OTM_REG_CUR_TIME       5'h10
`define OTM_REG_STATUS         5'h11

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTM_RST_SEL_OC1        16'h0000
`define OTM_RST_SEL_OC2        16'h0001
`define OTM_RST_SEL_OC3        16'h0002
`define OTM_RST_SEL_OC4        16'h0003
`define OTM_RST_SEL_OC5        16'h0004
`define OTM_RST_SEL_RLY1       16'h0063
`define OTM_RST_SEL_RLY2       16'h270F
`define OTM_RST_START_FREQ     16'h0032
`define OTM_RST_SU_BAND        16'h000A
`define OTM_RST_FDET           16'h0BB8
`define OTM_RST_REGEN_LIMIT    16'h0064
`define OTM_RST_THERM_TRIP     16'h03E8
`define OTM_RST_CUR_THR        16'h0064
`define OTM_RST_CUR_TIME       16'h0000

// ----------------------------------------
// selector codes
// ----------------------------------------
`define OTM_CODE_POS_MAX       16'h0063
`define OTM_CODE_NEG_BASE      16'h0064
`define OTM_CODE_NEG_MAX       16'h00C7
`define OTM_CODE_NONE          16'h270F

// ----------------------------------------
// status source bit positions
// ----------------------------------------
`define OTM_SRC_RUN            0
`define OTM_SRC_AT_SPEED       1
`define OTM_SRC_POWER_LOSS     2
`define OTM_SRC_STALL          3
`define OTM_SRC_FDET1          4
`define OTM_SRC_FDET2          5
`define OTM_SRC_FDET3          6
`define OTM_SRC_REGEN_PRE      7
`define OTM_SRC_THERM_PRE      8
`define OTM_SRC_PANEL          9
`define OTM_SRC_READY          10
`define OTM_SRC_CUR_DET        11
`define OTM_SRC_RUN_START      12
`define OTM_SRC_PF_DECEL       13
`define OTM_SRC_SERVO          14
`define OTM_SRC_FAULT          15

// ----------------------------------------
// timing
// ----------------------------------------
`define OTM_CLK_PERIOD_NS      50
`define OTM_TIME_UNIT_NS       1000000
`define OTM_PREALARM_PCT       24'h00_0055
`define OTM_FULL_PCT           24'h00_0064

`endif

// >>> otm_term_sel.v
`include "otm_map.vh"

module otm_term_sel (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // selection
    input  wire [15:0] code,
    input  wire [15:0] src,
    // terminal
    output reg         term
);

    reg  [15:0] base;
    reg         inv;
    reg         lvl;
    reg         next_term;

    // ----------------------------------------
    // function code to source level
    // ----------------------------------------
    function src_level;
        input [15:0] b;
        input [15:0] s;
        begin
            case (b)
                16'h0000: src_level = s[`OTM_SRC_RUN];
                16'h0001: src_level = s[`OTM_SRC_AT_SPEED];
                16'h0002: src_level = s[`OTM_SRC_POWER_LOSS];
                16'h0003: src_level = s[`OTM_SRC_STALL];
                16'h0004: src_level = s[`OTM_SRC_FDET1];
                16'h0005: src_level = s[`OTM_SRC_FDET2];
                16'h0006: src_level = s[`OTM_SRC_FDET3];
                16'h0007: src_level = s[`OTM_SRC_REGEN_PRE];
                16'h0008: src_level = s[`OTM_SRC_THERM_PRE];
                16'h000A: src_level = s[`OTM_SRC_PANEL];
                16'h000B: src_level = s[`OTM_SRC_READY];
                16'h000C: src_level = s[`OTM_SRC_CUR_DET];
                16'h002D: src_level = s[`OTM_SRC_RUN_START];
                16'h002E: src_level = s[`OTM_SRC_PF_DECEL];
                16'h0054: src_level = s[`OTM_SRC_SERVO];
                16'h005E, 16'h0063: src_level = s[`OTM_SRC_FAULT];
                // accepted codes without a producer here read low, so their inverted forms drive the terminal on
                default:  src_level = 1'b0;
            endcase
        end
    endfunction

    always @* begin
        base      = code;
        inv       = 1'b0;
        lvl       = 1'b0;
        next_term = 1'b0;
        if (code >= `OTM_CODE_NEG_BASE && code <= `OTM_CODE_NEG_MAX) begin
            base = code - `OTM_CODE_NEG_BASE;
            inv  = 1'b1;
        end
        lvl = src_level(base, src);
        if (code <= `OTM_CODE_NEG_MAX) begin
            next_term = lvl ^ inv;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            term <= 1'b0;
        end else begin
            term <= next_term;
        end
    end

endmodule // otm_term_sel

// >>> otm_cur_detect.v
module otm_cur_detect #(
    parameter TICK_CYCLES = 20000
) (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // condition and hold time in units
    input  wire        over,
    input  wire [15:0] hold_units,
    // result
    output reg         det
);

    reg  [31:0] pre;
    reg  [16:0] units;

    // continuous excess for longer than hold
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre   <= 32'h0000_0000;
            units <= 17'h0_0000;
            det   <= 1'b0;
        end else if (!over) begin
            pre   <= 32'h0000_0000;
            units <= 17'h0_0000;
            det   <= 1'b0;
        end else begin
            if (pre >= TICK_CYCLES - 1) begin
                pre <= 32'h0000_0000;
                if (units <= {1'b0, hold_units}) begin
                    units <= units + 17'h0_0001;
                end
            end else begin
                pre <= pre + 32'h0000_0001;
            end
            det <= (units > {1'b0, hold_units});
        end
    end

endmodule // otm_cur_detect

// >>> otm_output_mux.v
`include "otm_map.vh"

module otm_output_mux #(
    parameter TICK_CYCLES = `OTM_TIME_UNIT_NS / `OTM_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // register port
    input  wire [4:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // drive state from internal producers
    input  wire        drive_operating,
    input  wire        reverse_dir,
    input  wire [15:0] out_freq,
    input  wire [15:0] set_freq,
    input  wire [15:0] out_current,
    input  wire        inst_power_fail,
    input  wire        undervoltage,
    input  wire        stall_active,
    input  wire [15:0] regen_duty_used,
    input  wire [15:0] thermal_accum,
    input  wire        panel_mode,
    input  wire        reset_proc_done,
    input  wire        drive_startable,
    input  wire        start_cmd,
    input  wire        powerfail_decel,
    input  wire        position_ctrl,
    input  wire        fault_active,
    // external pin
    input  wire        servo_on_input,
    // terminals
    output wire [4:0]  oc_out,
    output wire        relay_terminal_1,
    output wire        relay_terminal_2,
    output reg         thermal_trip
);

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    reg  [15:0] sel_oc1;
    reg  [15:0] sel_oc2;
    reg  [15:0] sel_oc3;
    reg  [15:0] sel_oc4;
    reg  [15:0] sel_oc5;
    reg  [15:0] sel_rly1;
    reg  [15:0] sel_rly2;
    reg  [15:0] start_freq;
    reg  [15:0] su_band;
    reg  [15:0] fdet1;
    reg  [15:0] fdet1_rev;
    reg  [15:0] fdet2;
    reg  [15:0] fdet3;
    reg  [15:0] regen_limit;
    reg  [15:0] therm_trip_lvl;
    reg  [15:0] cur_thr;
    reg  [15:0] cur_time;

    // ----------------------------------------
    // status sources
    // ----------------------------------------
    reg         servo_meta;
    reg         servo_sync;
    reg         init_done;
    reg  [15:0] src;
    wire        cur_det;
    wire [15:0] freq_diff;
    wire [23:0] regen_scaled;
    wire [23:0] regen_limit_85;
    wire [23:0] therm_scaled;
    wire [23:0] therm_trip_85;
    wire [6:0]  terms;

    // ----------------------------------------
    // code acceptance
    // ----------------------------------------
    function code_ok;
        input [15:0] c;
        input        relay;
        reg   [15:0] b;
        begin
            b = c;
            if (c >= `OTM_CODE_NEG_BASE && c <= `OTM_CODE_NEG_MAX) begin
                b = c - `OTM_CODE_NEG_BASE;
            end
            if (c == `OTM_CODE_NONE) begin
                code_ok = 1'b1;
            end else if (c > `OTM_CODE_NEG_MAX) begin
                code_ok = 1'b0;
            end else begin
                case (b)
                    16'h0009, 16'h0015, 16'h0016, 16'h0017, 16'h0018,
                    16'h001D, 16'h0025, 16'h0026, 16'h0028:
                        code_ok = 1'b0;
                    16'h005C, 16'h005D:
                        code_ok = !relay;
                    default: begin
                        code_ok = (b <= 16'h0014) || (b == 16'h0027) || (b == 16'h0037) ||
                                  (b == 16'h0040) || (b == 16'h0046) ||
                                  (b >= 16'h0019 && b <= 16'h0024) || (b >= 16'h0029 && b <= 16'h002F) ||
                                  (b >= 16'h0053 && b <= 16'h0055) || (b >= 16'h005A && b <= `OTM_CODE_POS_MAX);
                    end
                endcase
            end
        end
    endfunction

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_oc1        <= `OTM_RST_SEL_OC1;
            sel_oc2        <= `OTM_RST_SEL_OC2;
            sel_oc3        <= `OTM_RST_SEL_OC3;
            sel_oc4        <= `OTM_RST_SEL_OC4;
            sel_oc5        <= `OTM_RST_SEL_OC5;
            sel_rly1       <= `OTM_RST_SEL_RLY1;
            sel_rly2       <= `OTM_RST_SEL_RLY2;
            start_freq     <= `OTM_RST_START_FREQ;
            su_band        <= `OTM_RST_SU_BAND;
            fdet1          <= `OTM_RST_FDET;
            fdet1_rev      <= `OTM_RST_FDET;
            fdet2          <= `OTM_RST_FDET;
            fdet3          <= `OTM_RST_FDET;
            regen_limit    <= `OTM_RST_REGEN_LIMIT;
            therm_trip_lvl <= `OTM_RST_THERM_TRIP;
            cur_thr        <= `OTM_RST_CUR_THR;
            cur_time       <= `OTM_RST_CUR_TIME;
        end else if (wr) begin
            // out-of-range selector codes are dropped, old code kept
            case (addr)
                `OTM_REG_SEL_OC1:     if (code_ok(wdata, 1'b0)) sel_oc1 <= wdata;
                `OTM_REG_SEL_OC2:     if (code_ok(wdata, 1'b0)) sel_oc2 <= wdata;
                `OTM_REG_SEL_OC3:     if (code_ok(wdata, 1'b0)) sel_oc3 <= wdata;
                `OTM_REG_SEL_OC4:     if (code_ok(wdata, 1'b0)) sel_oc4 <= wdata;
                `OTM_REG_SEL_OC5:     if (code_ok(wdata, 1'b0)) sel_oc5 <= wdata;
                `OTM_REG_SEL_RLY1:    if (code_ok(wdata, 1'b1)) sel_rly1 <= wdata;
                `OTM_REG_SEL_RLY2:    if (code_ok(wdata, 1'b1)) sel_rly2 <= wdata;
                `OTM_REG_START_FREQ:  start_freq <= wdata;
                `OTM_REG_SU_BAND:     su_band <= wdata;
                `OTM_REG_FDET1:       fdet1 <= wdata;
                `OTM_REG_FDET1_REV:   fdet1_rev <= wdata;
                `OTM_REG_FDET2:       fdet2 <= wdata;
                `OTM_REG_FDET3:       fdet3 <= wdata;
                `OTM_REG_REGEN_LIMIT: regen_limit <= wdata;
                `OTM_REG_THERM_TRIP:  therm_trip_lvl <= wdata;
                `OTM_REG_CUR_THR:     cur_thr <= wdata;
                `OTM_REG_CUR_TIME:    cur_time <= wdata;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `OTM_REG_SEL_OC1:     rdata <= sel_oc1;
                `OTM_REG_SEL_OC2:     rdata <= sel_oc2;
                `OTM_REG_SEL_OC3:     rdata <= sel_oc3;
                `OTM_REG_SEL_OC4:     rdata <= sel_oc4;
                `OTM_REG_SEL_OC5:     rdata <= sel_oc5;
                `OTM_REG_SEL_RLY1:    rdata <= sel_rly1;
                `OTM_REG_SEL_RLY2:    rdata <= sel_rly2;
                `OTM_REG_START_FREQ:  rdata <= start_freq;
                `OTM_REG_SU_BAND:     rdata <= su_band;
                `OTM_REG_FDET1:       rdata <= fdet1;
                `OTM_REG_FDET1_REV:   rdata <= fdet1_rev;
                `OTM_REG_FDET2:       rdata <= fdet2;
                `OTM_REG_FDET3:       rdata <= fdet3;
                `OTM_REG_REGEN_LIMIT: rdata <= regen_limit;
                `OTM_REG_THERM_TRIP:  rdata <= therm_trip_lvl;
                `OTM_REG_CUR_THR:     rdata <= cur_thr;
                `OTM_REG_CUR_TIME:    rdata <= cur_time;
                `OTM_REG_STATUS:      rdata <= {7'h00, thermal_trip, 1'b0, terms};
                default:              rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // pin synchroniser and init
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            servo_meta <= 1'b0;
            servo_sync <= 1'b0;
            init_done  <= 1'b0;
        end else begin
            servo_meta <= servo_on_input;
            servo_sync <= servo_meta;
            // held off until reset processing completes
            if (reset_proc_done) begin
                init_done <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // status derivation
    // ----------------------------------------
    assign freq_diff = (out_freq >= set_freq) ? (out_freq - set_freq) : (set_freq - out_freq);

    // widened so 85 percent compares exactly, without division
    assign regen_scaled   = {8'h00, regen_duty_used} * `OTM_FULL_PCT;
    assign regen_limit_85 = {8'h00, regen_limit} * `OTM_PREALARM_PCT;
    assign therm_scaled   = {8'h00, thermal_accum} * `OTM_FULL_PCT;
    assign therm_trip_85  = {8'h00, therm_trip_lvl} * `OTM_PREALARM_PCT;

    always @* begin
        src = 16'h0000;
        // running at or above start frequency
        src[`OTM_SRC_RUN]        = drive_operating && (out_freq >= start_freq);
        src[`OTM_SRC_AT_SPEED]   = drive_operating && (freq_diff <= su_band);
        src[`OTM_SRC_POWER_LOSS] = inst_power_fail || undervoltage;
        src[`OTM_SRC_STALL]      = stall_active;
        // separate reverse threshold for first detect
        src[`OTM_SRC_FDET1]      = reverse_dir ? (out_freq >= fdet1_rev) : (out_freq >= fdet1);
        src[`OTM_SRC_FDET2]      = out_freq >= fdet2;
        src[`OTM_SRC_FDET3]      = out_freq >= fdet3;
        src[`OTM_SRC_REGEN_PRE]  = regen_scaled >= regen_limit_85;
        src[`OTM_SRC_THERM_PRE]  = therm_scaled >= therm_trip_85;
        src[`OTM_SRC_PANEL]      = panel_mode;
        src[`OTM_SRC_READY]      = init_done && (drive_startable || drive_operating);
        src[`OTM_SRC_CUR_DET]    = cur_det;
        src[`OTM_SRC_RUN_START]  = drive_operating && start_cmd;
        src[`OTM_SRC_PF_DECEL]   = powerfail_decel;
        src[`OTM_SRC_SERVO]      = position_ctrl && servo_sync;
        src[`OTM_SRC_FAULT]      = fault_active;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            thermal_trip <= 1'b0;
        end else begin
            thermal_trip <= (thermal_accum >= therm_trip_lvl);
        end
    end

    // ----------------------------------------
    // current detection timer
    // ----------------------------------------
    // timed excess over threshold
    otm_cur_detect #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_cur_detect (
        .clk        (clk),
        .rstn       (rstn),
        .over       (out_current > cur_thr),
        .hold_units (cur_time),
        .det        (cur_det)
    );

    // ----------------------------------------
    // terminal selectors
    // ----------------------------------------
    // one registered selector per terminal
    otm_term_sel u_sel_oc1 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_oc1),
        .src  (src),
        .term (terms[0])
    );
    otm_term_sel u_sel_oc2 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_oc2),
        .src  (src),
        .term (terms[1])
    );
    otm_term_sel u_sel_oc3 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_oc3),
        .src  (src),
        .term (terms[2])
    );
    otm_term_sel u_sel_oc4 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_oc4),
        .src  (src),
        .term (terms[3])
    );
    otm_term_sel u_sel_oc5 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_oc5),
        .src  (src),
        .term (terms[4])
    );
    otm_term_sel u_sel_rly1 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_rly1),
        .src  (src),
        .term (terms[5])
    );
    otm_term_sel u_sel_rly2 (
        .clk  (clk),
        .rstn (rstn),
        .code (sel_rly2),
        .src  (src),
        .term (terms[6])
    );

    assign oc_out           = terms[4:0];
    assign relay_terminal_1 = terms[5];
    assign relay_terminal_2 = terms[6];

endmodule // otm_output_mux

// >>> otm_output_mux_properties.sv
`include "otm_map.vh"

module otm_output_mux_properties (
    // clock and reset
    input wire        clk,
    input wire        rstn,
    // register port
    input wire [4:0]  addr,
    input wire        wr,
    input wire        rd,
    input wire [15:0] rdata,
    // producers
    input wire        drive_operating,
    input wire [15:0] out_freq,
    input wire [15:0] thermal_accum,
    input wire        inst_power_fail,
    input wire        undervoltage,
    input wire        stall_active,
    input wire        fault_active,
    // terminals
    input wire [4:0]  oc_out,
    input wire        relay_terminal_1,
    input wire        relay_terminal_2,
    input wire        thermal_trip
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // settings still at reset value
    // ----
    // any write to words 0x00 to 0x10 retires a check, refused ones too: cheaper than modelling acceptance
    reg [16:0] clean;
    reg        live;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clean <= 17'h1_FFFF;
            live  <= 1'b0;
        end else begin
            live <= 1'b1;
            if (wr && addr <= 5'h10)
                clean[addr] <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----
    // properties
    // ----
    read_idle_zero_a: assert property (
        !rd |=> rdata == 16'h0000) else $error("read data not zero");
    relay_reset_read_a: assert property (
        rd && addr == `OTM_REG_SEL_RLY1 ##1 clean[5] |-> rdata == `OTM_RST_SEL_RLY1) else $error("relay reset code");
    overload_follow_a: assert property (
        live && clean[3] |-> oc_out[3] == $past(stall_active)) else $error("overload terminal");
    power_loss_a: assert property (
        live && clean[2] |-> oc_out[2] == ($past(inst_power_fail) | $past(undervoltage))) else $error("power loss");
    fault_relay_a: assert property (
        live && clean[5] |-> relay_terminal_1 == $past(fault_active)) else $error("fault relay");
    relay_two_idle_a: assert property (
        clean[6] |-> !relay_terminal_2) else $error("unused relay driven");
    thermal_trip_a: assert property (
        live && clean[14] |-> thermal_trip == ($past(thermal_accum) >= `OTM_RST_THERM_TRIP)) else $error("trip");
    freq_detect_a: assert property (
        live && clean[4] && clean[9] && clean[10] |-> oc_out[4] == ($past(out_freq) >= `OTM_RST_FDET))
        else $error("frequency detect");
    running_out_a: assert property (
        live && clean[0] && clean[7] |-> oc_out[0] == ($past(drive_operating) && $past(out_freq) >= `OTM_RST_START_FREQ))
        else $error("running terminal");
endmodule // otm_output_mux_properties

bind otm_output_mux otm_output_mux_properties otm_output_mux_properties_i (
    .clk(clk), .rstn(rstn), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .drive_operating(drive_operating), .out_freq(out_freq), .thermal_accum(thermal_accum),
    .inst_power_fail(inst_power_fail), .undervoltage(undervoltage), .stall_active(stall_active),
    .fault_active(fault_active), .oc_out(oc_out), .relay_terminal_1(relay_terminal_1),
    .relay_terminal_2(relay_terminal_2), .thermal_trip(thermal_trip));

// >>> otm_far_side.sv
module otm_far_side (
    // request from bench
    input  wire  servo_req,
    // pin toward the block
    output logic servo_on_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // servo switch
    // ----
    // contact moves off the clock grid on purpose, to exercise the synchroniser
    initial servo_on_input = 1'b0;
    always @(servo_req) servo_on_input <= #17 servo_req;
endmodule // otm_far_side

// >>> otm_output_mux_tb.sv
`include "otm_map.vh"

module otm_output_mux_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, oper = 1'b0, rev = 1'b0, go = 1'b0, pm = 1'b0;
    logic        power_loss_flag = 1'b0, uv = 1'b0, stall = 1'b0, fault = 1'b0, rdone = 1'b0, pos = 1'b0, srv = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000, freq = 16'h0000, cur = 16'h0000, therm = 16'h0000;
    wire  [15:0] rdata;
    wire  [4:0]  oc;
    wire         rly1, rly2, trip, servo;
    wire  [15:0] term = {8'h00, trip, rly2, rly1, oc};
    int          n_fail = 0, num_checks = 0;
    logic [4:0]  ka [6] = '{5'h02, 5'h02, 5'h02, 5'h05, 5'h05, 5'h05};
    logic [15:0] kw [6] = '{16'h005C, 16'h00C1, 16'h00C8, 16'h005C, 16'h00C1, 16'h00C2};
    logic [15:0] ke [6] = '{16'h005C, 16'h00C1, 16'h00C1, 16'h0063, 16'h0063, 16'h00C2};

    always #25 clk = ~clk;

    // short time unit keeps the current-detect wait small
    otm_output_mux #(.TICK_CYCLES(4)) otm_output_mux_i (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .drive_operating(oper), .reverse_dir(rev), .out_freq(freq), .set_freq(16'h0000),
        .out_current(cur), .inst_power_fail(power_loss_flag), .undervoltage(uv), .stall_active(stall),
        .regen_duty_used(16'h0000), .thermal_accum(therm), .panel_mode(pm),
        .reset_proc_done(rdone), .drive_startable(go), .start_cmd(1'b0), .powerfail_decel(1'b0),
        .position_ctrl(pos), .fault_active(fault), .servo_on_input(servo), .oc_out(oc),
        .relay_terminal_1(rly1), .relay_terminal_2(rly2), .thermal_trip(trip));
    otm_far_side otm_far_side_i (.servo_req(srv), .servo_on_input(servo));

    // ----
    // bus and compare
    // ----
    task automatic chk(input string nm, input [15:0] e, input [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic see(input int n, input [15:0] e);
        tick(n);
        chk("term", e, term);
        @(posedge clk);
    endtask
    task automatic reg_wr(input [4:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input [4:0] a, input [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        see(1, 16'h0000);
        for (int k = 0; k < 5; k++)
            reg_rd(k[4:0], `OTM_RST_SEL_OC1 + k[15:0]);
        reg_rd(`OTM_REG_SEL_RLY1, `OTM_RST_SEL_RLY1);
        reg_rd(`OTM_REG_SEL_RLY2, `OTM_RST_SEL_RLY2);
        reg_rd(5'h1F, 16'h0000);
    endtask
    task automatic t_sources;
        @(posedge clk);
        stall <= 1'b1;
        see(1, 16'h0008);
        stall <= 1'b0;
        power_loss_flag <= 1'b1;
        see(1, 16'h0004);
        power_loss_flag <= 1'b0;
        uv <= 1'b1;
        fault <= 1'b1;
        see(1, 16'h0024);
        uv <= 1'b0;
        fault <= 1'b0;
    endtask
    task automatic t_logic;
        @(posedge clk);
        oper <= 1'b1;
        freq <= `OTM_RST_START_FREQ;
        see(1, 16'h0001);
        freq <= `OTM_RST_START_FREQ - 16'h0001;
        see(1, 16'h0000);
        reg_wr(`OTM_REG_SEL_OC1, 16'h0064);
        see(1, 16'h0001);
        reg_wr(`OTM_REG_SEL_OC1, 16'h00C7);
        see(1, 16'h0001);
        reg_wr(`OTM_REG_SEL_OC1, 16'h006E);
        pm <= 1'b1;
        see(1, 16'h0000);
        reg_wr(`OTM_REG_SEL_OC1, 16'h0000);
        oper <= 1'b0;
        freq <= 16'h0000;
        pm <= 1'b0;
    endtask
    task automatic t_accept;
        for (int k = 0; k < 6; k++) begin
            reg_wr(ka[k], kw[k]);
            reg_rd(ka[k], ke[k]);
        end
        chk("term", 16'h0024, term);
        reg_wr(`OTM_REG_SEL_RLY1, `OTM_RST_SEL_RLY1);
        reg_wr(`OTM_REG_SEL_OC3, `OTM_RST_SEL_OC3);
    endtask
    task automatic t_freq;
        @(posedge clk);
        freq <= `OTM_RST_FDET;
        see(1, 16'h0010);
        freq <= `OTM_RST_FDET - 16'h0001;
        see(1, 16'h0000);
        reg_wr(`OTM_REG_FDET1_REV, 16'h0100);
        rev <= 1'b1;
        freq <= 16'h0100;
        see(1, 16'h0010);
        rev <= 1'b0;
        see(1, 16'h0000);
    endtask
    task automatic t_thermal;
        reg_wr(`OTM_REG_SEL_OC4, 16'h0008);
        therm <= 16'h0351;
        see(1, 16'h0000);
        therm <= 16'h0352;
        see(1, 16'h0008);
        therm <= `OTM_RST_THERM_TRIP;
        see(1, 16'h0088);
        reg_rd(`OTM_REG_STATUS, 16'h0108);
        @(posedge clk);
        therm <= 16'h0000;
    endtask
    task automatic t_ready;
        reg_wr(`OTM_REG_SEL_OC4, 16'h000B);
        go <= 1'b1;
        see(2, 16'h0000);
        rdone <= 1'b1;
        @(posedge clk);
        rdone <= 1'b0;
        see(3, 16'h0008);
        go <= 1'b0;
        see(1, 16'h0000);
    endtask
    task automatic t_curdet;
        int n;
        reg_wr(`OTM_REG_SEL_OC2, 16'h000C);
        cur <= `OTM_RST_CUR_THR + 16'h0001;
        n = 0;
        while (term !== 16'h0002 && n < 20) begin
            tick(1);
            n++;
        end
        chk("cur_delay", 16'h0001, {15'h0000, n >= 4 && n < 20});
        @(posedge clk);
        cur <= `OTM_RST_CUR_THR;
        see(3, 16'h0000);
    endtask
    task automatic t_servo;
        reg_wr(`OTM_REG_SEL_RLY2, 16'h0054);
        pos <= 1'b1;
        srv <= 1'b1;
        see(6, 16'h0040);
        srv <= 1'b0;
        see(6, 16'h0000);
    endtask
    task automatic t_rerun;
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        reg_rd(`OTM_REG_SEL_OC2, `OTM_RST_SEL_OC2);
        reg_rd(`OTM_REG_SEL_RLY2, `OTM_RST_SEL_RLY2);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_sources;
        t_logic;
        t_accept;
        t_freq;
        t_thermal;
        t_ready;
        t_curdet;
        t_servo;
        t_rerun;
        summarize;
    end
    initial begin
        #200000;
        n_fail++;
        summarize;
    end
endmodule // otm_output_mux_tb
